// ---- pkg/id_scratch_pkg.sv ----
// constants shared by the identification and scratchpad register bank
package id_scratch_pkg;

  // ---------------------------------------------------------------
  // command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_PROTOCOL_FLAGS = 8'h19;
  localparam logic [7:0] CMD_BUS_REVISION   = 8'h98;
  localparam logic [7:0] CMD_TOOL_WORD_A    = 8'hB0;
  localparam logic [7:0] CMD_TOOL_WORD_B    = 8'hB1;
  localparam logic [7:0] CMD_OEM_WORD       = 8'hB2;
  localparam logic [7:0] CMD_PAGED_SCRATCH  = 8'hB3;
  localparam logic [7:0] CMD_GLOBAL_SCRATCH = 8'hB4;
  localparam logic [7:0] CMD_ECC_INFO       = 8'hB6;
  localparam logic [7:0] CMD_MAKER_RESERVED = 8'hBC;
  localparam logic [7:0] CMD_MAKER_PART     = 8'hE7;
  localparam logic [7:0] CMD_FACTORY_LOT    = 8'hE8;

  // ---------------------------------------------------------------
  // capability byte fields
  // ---------------------------------------------------------------
  localparam int         CAP_PEC_BIT       = 7;
  localparam int         CAP_SCL_LSB       = 5;
  localparam logic [1:0] CAP_SCL_400K      = 2'h1;
  localparam int         CAP_ALERT_BIT     = 4;
  localparam logic [7:0] PROTOCOL_FLAGS_RV = 8'hB0;
  localparam logic [7:0] BUS_REVISION_RV   = 8'h11;

  // ---------------------------------------------------------------
  // ecc info word and reset values
  // ---------------------------------------------------------------
  localparam int          ECC_USER_BIT  = 5;
  localparam logic [15:0] SCRATCH_RV    = 16'h0000;
  localparam logic [15:0] TOOL_WORD_RV  = 16'h0000;
  localparam logic [15:0] ECC_INFO_RV   = 16'h0000;

  // ---------------------------------------------------------------
  // fault log block readout
  // ---------------------------------------------------------------
  localparam logic [7:0] LOG_LAST_VALID = 8'hED;
  localparam logic [7:0] LOG_LAST_BYTE  = 8'hFE;
  localparam logic [7:0] LOG_FILL_BYTE  = 8'h00;

  typedef enum logic [1:0]
  {
    ST_RESET_LOAD = 2'h0,
    ST_IDLE       = 2'h1,
    ST_RELOAD     = 2'h3
  } bank_state_t;

endpackage

// ---- src/id_scratch_regs.sv ----
// identification, info and scratchpad register bank with fault log tail
`timescale 1ns/10ps

// Operation
// - capability read at 0x19 returns 0xB0, low nibble zero
// - capability bit 7 set: packet error checking supported
// - pec required state reported by separate configuration bit
// - capability bits 6:5 are 01b: 400kHz maximum clock
// - capability bit 4 set: alert pin and alert response supported
// - revision read at 0x98 always returns 0x11
// - 0xE7 word returns fixed unpaged maker part code
// - 0xE8 byte returns per-page factory lot code
// - ecc info refreshed after reset, reload command and bulk read
// - info bit 5 low when corrections made, others reserved zero
// - 0xB0 unpaged and 0xB1 paged read/write words
// - log bytes past 0xED read 0x00 up to 0xFE
module id_scratch_regs
  import id_scratch_pkg::*;
#(
  parameter int          PAGES          = 2,
  parameter logic [15:0] MAKER_PART_ID  = 16'h5A5A, // arbitrary value
  parameter logic [15:0] LOT_CODE_BASE  = 16'h00A0  // arbitrary value
)
(
  input  wire logic        clk,             // 20 MHz device clock
  input  wire logic        reset,           // synchronous, active high
  input  wire logic        cmd_valid,       // one-cycle command strobe
  input  wire logic        cmd_write,       // 1 write word, 0 read
  input  wire logic [7:0]  cmd_code,        // command code
  input  wire logic        cmd_page,        // selected page
  input  wire logic [15:0] cmd_wdata,       // write word
  input  wire logic        reload_req,      // reload-user-config pulse
  input  wire logic        bulk_read_done,  // eeprom bulk read pulse
  input  wire logic        ecc_corrected,   // eeprom user space corrected
  input  wire logic        pec_cfg_en,      // configuration pec enable
  input  wire logic        log_rd,          // fault log byte request
  input  wire logic [7:0]  log_index,       // byte number in block
  input  wire logic [7:0]  log_src_byte,    // byte from log storage
  output logic             rd_valid,        // read answer pulse
  output logic [15:0]      rd_data,         // read word, bytes low
  output logic             cmd_err,         // unsupported code pulse
  output logic             log_valid,       // log answer pulse
  output logic [7:0]       log_data,        // log byte
  output logic             log_err,         // index outside block
  output logic             pec_required     // pec currently mandatory
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed
  {
    bank_state_t          st;
    logic [15:0]          tool_a;
    logic [1:0][15:0]     tool_b;
    logic [15:0]          oem;
    logic [1:0][15:0]     paged_scratch;
    logic [15:0]          global_scratch;
    logic [1:0][15:0]     maker_rsvd;
    logic [15:0]          ecc_info;
    logic                 rd_valid;
    logic [15:0]          rd_data;
    logic                 cmd_err;
    logic                 log_valid;
    logic [7:0]           log_data;
    logic                 log_err;
    logic                 pec_required;
  } bank_t;

  bank_t state_ff;
  bank_t nxt_state;

  logic [7:0] protocol_flags;
  logic       pg;

  assign pg = cmd_page;

  // fixed byte built field by field, reserved nibble zero
  always_comb
  begin
    protocol_flags                                   = 8'h00;
    protocol_flags[CAP_PEC_BIT]                      = 1'b1;
    protocol_flags[CAP_SCL_LSB+1:CAP_SCL_LSB]        = CAP_SCL_400K;
    protocol_flags[CAP_ALERT_BIT]                    = 1'b1;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_state              = state_ff;
    nxt_state.rd_valid     = 1'b0;
    nxt_state.cmd_err      = 1'b0;
    nxt_state.log_valid    = 1'b0;
    nxt_state.log_err      = 1'b0;
    nxt_state.pec_required = pec_cfg_en;

    case (state_ff.st)
      ST_RESET_LOAD, ST_RELOAD:
      begin
        // capture ecc status once eeprom contents are settled
        nxt_state.ecc_info               = ECC_INFO_RV;
        nxt_state.ecc_info[ECC_USER_BIT] = ~ecc_corrected;
        nxt_state.st                     = ST_IDLE;
      end
      ST_IDLE:
      begin
        if (reload_req || bulk_read_done)
          nxt_state.st = ST_RELOAD;
      end
      default:
      begin
        nxt_state.st = ST_IDLE;
      end
    endcase

    if (cmd_valid && cmd_write)
    begin
      case (cmd_code)
        CMD_TOOL_WORD_A:    nxt_state.tool_a             = cmd_wdata;
        CMD_TOOL_WORD_B:    nxt_state.tool_b[pg]         = cmd_wdata;
        CMD_OEM_WORD:       nxt_state.oem                = cmd_wdata;
        CMD_PAGED_SCRATCH:  nxt_state.paged_scratch[pg]  = cmd_wdata;
        CMD_GLOBAL_SCRATCH: nxt_state.global_scratch     = cmd_wdata;
        CMD_MAKER_RESERVED: nxt_state.maker_rsvd[pg]     = cmd_wdata;
        default:            nxt_state.cmd_err            = 1'b1;
      endcase
    end
    else if (cmd_valid)
    begin
      nxt_state.rd_valid = 1'b1;
      nxt_state.rd_data  = 16'h0000;
      case (cmd_code)
        CMD_PROTOCOL_FLAGS: nxt_state.rd_data = {8'h00, protocol_flags};
        CMD_BUS_REVISION:   nxt_state.rd_data = {8'h00, BUS_REVISION_RV};
        CMD_TOOL_WORD_A:    nxt_state.rd_data = state_ff.tool_a;
        CMD_TOOL_WORD_B:    nxt_state.rd_data = state_ff.tool_b[pg];
        CMD_OEM_WORD:       nxt_state.rd_data = state_ff.oem;
        CMD_PAGED_SCRATCH:  nxt_state.rd_data = state_ff.paged_scratch[pg];
        CMD_GLOBAL_SCRATCH: nxt_state.rd_data = state_ff.global_scratch;
        CMD_ECC_INFO:       nxt_state.rd_data = state_ff.ecc_info;
        CMD_MAKER_RESERVED: nxt_state.rd_data = state_ff.maker_rsvd[pg];
        CMD_MAKER_PART:     nxt_state.rd_data = MAKER_PART_ID;
        CMD_FACTORY_LOT:    nxt_state.rd_data = {8'h00, LOT_CODE_BASE[7:0] + {7'h00, pg}};
        default:
        begin
          nxt_state.rd_valid = 1'b0;
          nxt_state.cmd_err  = 1'b1;
        end
      endcase
    end

    // host must still clock out every byte through 0xFE
    if (log_rd)
    begin
      nxt_state.log_valid = 1'b1;
      if (log_index <= LOG_LAST_VALID)
        nxt_state.log_data = log_src_byte;
      else
        nxt_state.log_data = LOG_FILL_BYTE;
      nxt_state.log_err = (log_index > LOG_LAST_BYTE);
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_ff                <= '0;
      state_ff.st             <= ST_RESET_LOAD;
      state_ff.tool_a         <= TOOL_WORD_RV;
      state_ff.tool_b         <= {2{TOOL_WORD_RV}};
      state_ff.oem            <= TOOL_WORD_RV;
      state_ff.paged_scratch  <= {2{SCRATCH_RV}};
      state_ff.global_scratch <= SCRATCH_RV;
      state_ff.maker_rsvd     <= {2{TOOL_WORD_RV}};
      state_ff.ecc_info       <= ECC_INFO_RV;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign rd_valid     = state_ff.rd_valid;
  assign rd_data      = state_ff.rd_data;
  assign cmd_err      = state_ff.cmd_err;
  assign log_valid    = state_ff.log_valid;
  assign log_data     = state_ff.log_data;
  assign log_err      = state_ff.log_err;
  assign pec_required = state_ff.pec_required;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_read(logic [7:0] c);
    cmd_valid && !cmd_write && cmd_code == c;
  endsequence

  chk_flags_value: assert property (s_read(CMD_PROTOCOL_FLAGS) |=> rd_valid && rd_data == 16'h00B0)
    else $error("capability byte wrong");
  chk_flags_pec: assert property (s_read(CMD_PROTOCOL_FLAGS) |=> rd_data[7] && rd_data[3:0] == 4'h0)
    else $error("capability pec or reserved bits wrong");
  chk_pec_follows: assert property (pec_cfg_en |=> pec_required)
    else $error("pec required not reported");
  chk_flags_speed: assert property (s_read(CMD_PROTOCOL_FLAGS) |=> rd_data[6:5] == 2'h1 && rd_data[4])
    else $error("capability speed or alert bits wrong");
  chk_revision_val: assert property (s_read(CMD_BUS_REVISION) |=> rd_valid && rd_data == 16'h0011)
    else $error("revision byte wrong");
  chk_part_code: assert property (s_read(CMD_MAKER_PART) |=> rd_data == MAKER_PART_ID)
    else $error("part code wrong");
  chk_lot_paged: assert property (s_read(CMD_FACTORY_LOT) ##0 cmd_page |=> rd_data[0] != LOT_CODE_BASE[0])
    else $error("lot code not paged");
  chk_ecc_refresh: assert property ((reload_req || bulk_read_done) && state_ff.st == ST_IDLE
                                    ##1 ecc_corrected |=> !state_ff.ecc_info[5])
    else $error("ecc info not refreshed");
  chk_ecc_reserved: assert property (state_ff.ecc_info[15:6] == 10'h000 && state_ff.ecc_info[4:0] == 5'h00)
    else $error("ecc info reserved bits set");
  chk_tool_word: assert property (cmd_valid && cmd_write && cmd_code == CMD_TOOL_WORD_A
                                  ##1 s_read(CMD_TOOL_WORD_A) |=> rd_data == $past(cmd_wdata, 2))
    else $error("tool word not stored");
  chk_log_fill: assert property (log_rd && log_index > 8'hED |=> log_valid && log_data == 8'h00)
    else $error("log fill byte not zero");
  chk_scratch_word: assert property (cmd_valid && cmd_write && cmd_code == CMD_GLOBAL_SCRATCH
                                     ##1 s_read(CMD_GLOBAL_SCRATCH) |=> rd_data == $past(cmd_wdata, 2))
    else $error("scratch word not stored");

endmodule

// ---- tb/host_model.sv ----
// partner model: host controller issuing command transfers
`timescale 1ns/10ps
module host_model
(
  input  wire logic        clk,       // device clock
  output logic             cmd_valid, // command strobe
  output logic             cmd_write, // write select
  output logic [7:0]       cmd_code,  // command code
  output logic             cmd_page,  // page select
  output logic [15:0]      cmd_wdata, // write word
  input  wire logic        rd_valid,  // read answer
  input  wire logic [15:0] rd_data,   // read word
  input  wire logic        cmd_err    // refusal
);
  initial
  begin
    {cmd_valid, cmd_write, cmd_page} = 3'h0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
  // request held for exactly the taking edge; answer sampled 1 ns after that same edge
  task automatic xfer(input logic wr, input logic [7:0] code, input logic pg, input logic [15:0] wd,
                      output logic [17:0] resp);
    @(posedge clk);
    #1;
    {cmd_valid, cmd_write, cmd_code, cmd_page, cmd_wdata} = {1'b1, wr, code, pg, wd};
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    cmd_wdata = ~wd;
    resp = {rd_valid, cmd_err, rd_data};
  endtask
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench for the identification and scratchpad register bank
`timescale 1ns/10ps
module tb_top;
  import id_scratch_pkg::*;
  localparam logic [15:0] PART_ID = 16'h3C3C; // arbitrary value
  logic clk = 1'b0, reset = 1'b1, reload_req = 1'b0, bulk_read_done = 1'b0, ecc_corrected = 1'b0;
  logic pec_cfg_en = 1'b0, log_rd = 1'b0, pec_required, log_valid, log_err;
  logic cmd_valid, cmd_write, cmd_page, rd_valid, cmd_err;
  logic [7:0] cmd_code, log_data, log_index = 8'h00, log_src_byte = 8'h00;
  logic [15:0] cmd_wdata, rd_data;
  logic [17:0] resp;
  logic [7:0] rw_codes [6] = '{8'hB0, 8'hB1, 8'hB2, 8'hB3, 8'hB4, 8'hBC};
  logic rw_paged [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  int model [int];
  int err_total = 0, compares = 0, seed = 96384, k, c, p;

  always #25 clk = ~clk;

  id_scratch_regs #(.MAKER_PART_ID(PART_ID)) dut
  (
    .clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
    .cmd_page(cmd_page), .cmd_wdata(cmd_wdata), .reload_req(reload_req), .bulk_read_done(bulk_read_done),
    .ecc_corrected(ecc_corrected), .pec_cfg_en(pec_cfg_en), .log_rd(log_rd), .log_index(log_index),
    .log_src_byte(log_src_byte), .rd_valid(rd_valid), .rd_data(rd_data), .cmd_err(cmd_err),
    .log_valid(log_valid), .log_data(log_data), .log_err(log_err), .pec_required(pec_required)
  );
  host_model host
  (
    .clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_page(cmd_page),
    .cmd_wdata(cmd_wdata), .rd_valid(rd_valid), .rd_data(rd_data), .cmd_err(cmd_err)
  );

  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // read answer must be valid, not refused, carrying the expected word
  task automatic rd(input logic [7:0] code, input logic pg, input logic [15:0] exp);
    host.xfer(1'b0, code, pg, 16'h0000, resp);
    check(resp, {2'h2, exp});
  endtask
  task automatic pulse(ref logic s);
    @(posedge clk);
    #1;
    s = 1'b1;
    @(posedge clk);
    #1;
    s = 1'b0;
  endtask
  task automatic results;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // watchdog: whole sequence needs well under 3000 cycles
  // ---------------------------------------------------------------
  initial
  begin
    #(50 * 20000);
    err_total++;
    results();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge clk);
    #1;
    reset = 1'b0;
    check({rd_valid, cmd_err, rd_data}, 18'h0);
    rd(CMD_PROTOCOL_FLAGS, 1'b1, 16'h00B0);
    rd(CMD_BUS_REVISION, 1'b0, 16'h0011);
    rd(CMD_MAKER_PART, 1'b1, PART_ID);
    for (p = 0; p < 2; p++)
      rd(CMD_FACTORY_LOT, p[0], {8'h00, 8'hA0 + 8'(p)});
    rd(CMD_ECC_INFO, 1'b0, 16'h0020);
    for (p = 0; p < 2; p++)
      rd(rw_codes[3 + p], p[0], 16'h0000);
    // the copy lands on the edge that sampled the pulse and drops one edge later
    pulse(pec_cfg_en);
    check({17'h0, pec_required}, 18'h1);
    @(posedge clk);
    #1;
    check({17'h0, pec_required}, 18'h0);
    pec_cfg_en = 1'b1;
    @(posedge clk);
    #1;
    check({17'h0, pec_required}, 18'h1);
    ecc_corrected = 1'b1;
    pulse(reload_req);
    // refresh lands one edge after the pulse is sampled
    @(posedge clk);
    #1;
    rd(CMD_ECC_INFO, 1'b0, 16'h0000);
    ecc_corrected = 1'b0;
    pulse(bulk_read_done);
    @(posedge clk);
    #1;
    rd(CMD_ECC_INFO, 1'b1, 16'h0020);
    // random writes; unpaged words ignore the page bit
    for (k = 0; k < 40; k++)
    begin
      c = {$random(seed)} % 6;
      p = rw_paged[c] ? {$random(seed)} % 2 : 0;
      model[c * 2 + p] = $random(seed) & 16'hFFFF;
      host.xfer(1'b1, rw_codes[c], rw_paged[c] ? p[0] : ~p[0], 16'(model[c * 2 + p]), resp);
      check(resp[17:16], 2'h0);
    end
    for (k = 0; k < 12; k++)
      rd(rw_codes[k / 2], k[0], 16'(model.exists(rw_paged[k / 2] ? k : k & ~1) ? model[rw_paged[k / 2] ? k : k & ~1] : 0));
    host.xfer(1'b1, CMD_PROTOCOL_FLAGS, 1'b0, 16'hFFFF, resp);
    check(resp[17:16], 2'h1);
    rd(CMD_PROTOCOL_FLAGS, 1'b0, 16'h00B0);
    host.xfer(1'b0, 8'h00, 1'b0, 16'h0000, resp);
    check(resp[17:16], 2'h1);
    // host reads all 255 bytes plus one index beyond the block
    for (k = 0; k < 256; k++)
    begin
      @(posedge clk);
      #1;
      {log_rd, log_index, log_src_byte} = {1'b1, 8'(k), 8'($random(seed))};
      c = (k <= 8'hED) ? log_src_byte : 0;
      @(posedge clk);
      #1;
      log_rd = 1'b0;
      check({log_valid, log_err, 8'h00, log_data}, {1'b1, k == 255, 16'(c)});
    end
    results();
  end
endmodule
